//--- hw/pdmac_channel.sv
// peripheral dma channel: registers, pointer/counter sets, mover engine
`timescale 1ns/10ps
module pdmac_channel
    import pdmac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // ahb-lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // peripheral side, reached through the bus bridge
    input wire logic rxReady,
    input wire logic txReady,
    input wire logic [31:0] perRxData,
    output logic [31:0] perTxData,
    output logic perTxWrite,
    output logic perRxRead,
    output logic rxEndFlag,
    output logic txEndFlag,
    output logic rxBufferFullFlag,
    output logic txBufferEmptyFlag,
    output logic rxEnabled,
    output logic txEnabled,
    // memory master side
    output logic memReq,
    output logic memWrite,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    output logic [1:0] memSize,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    typedef struct packed {
        pdmac_dir_type rx;
        pdmac_dir_type tx;
        logic rxEn;
        logic txEn;
        logic halfDuplex;
        pdmac_size_type size;
        logic rxEnd;
        logic txEnd;
        logic rxFull;
        logic txEmpty;
        pdmac_bus_type bus;
        pdmac_state_type state;
        // address of the item in flight, held until acknowledged
        logic [31:0] addr;
        // pointer rewritten while its item is in flight
        logic ptrNew;
        logic [31:0] data;
        logic [31:0] rdata;
        logic perTxWr;
        logic perRxRd;
        logic [1:0] rxSync;
        logic [1:0] txSync;
    } pdmac_state_all_type;

    pdmac_state_all_type s_q, s_d;

    // advance one direction after an item; reload when drained
    function automatic pdmac_dir_type stepDir(input pdmac_dir_type d,
                                              input logic [2:0] inc);
        pdmac_dir_type r;
        r = d;
        r.ptr = d.ptr + {29'h0000_0000, inc};
        r.cnt = d.cnt - 16'h0001;
        if (r.cnt == CNT_RESET && d.ncnt != CNT_RESET) begin
            r.ptr = d.nptr;
            r.cnt = d.ncnt;
            r.nptr = PTR_RESET;
            r.ncnt = CNT_RESET;
        end
        return r;
    endfunction

    logic [2:0] incBytes;
    logic wrNow;
    logic [7:0] wa;
    logic rxGo;
    logic txGo;

    always_comb begin
        s_d = s_q;
        s_d.perTxWr = 1'b0;
        s_d.perRxRd = 1'b0;
        // peripheral requests come from another block; resynchronise
        s_d.rxSync = {s_q.rxSync[0], rxReady};
        s_d.txSync = {s_q.txSync[0], txReady};
        case (s_q.size)
            SZ_BYTE: incBytes = 3'h1;
            SZ_HALF: incBytes = 3'h2;
            default: incBytes = 3'h4;
        endcase
        // ahb address phase capture
        if (hsel && hready && htrans[1]) begin
            s_d.bus.valid = 1'b1;
            s_d.bus.write = hwrite;
            s_d.bus.addr = haddr[7:0];
        end else if (hready) begin
            s_d.bus.valid = 1'b0;
        end
        wrNow = s_q.bus.valid && s_q.bus.write;
        wa = s_q.bus.addr;
        // engine first; a software write in the same cycle wins over it
        rxGo = s_q.rxEn && s_q.rx.cnt != CNT_RESET && s_q.rxSync[1];
        txGo = s_q.txEn && s_q.tx.cnt != CNT_RESET && s_q.txSync[1];
        case (s_q.state)
            ST_IDLE: begin
                if (rxGo) begin
                    s_d.addr = s_q.rx.ptr;
                    s_d.ptrNew = 1'b0;
                    s_d.data = perRxData;
                    s_d.perRxRd = 1'b1;
                    s_d.state = ST_WRITE;
                end else if (txGo) begin
                    s_d.addr = s_q.tx.ptr;
                    s_d.ptrNew = 1'b0;
                    s_d.state = ST_READ;
                end
            end
            ST_READ: begin
                if (memAck) begin
                    s_d.data = memRdata;
                    s_d.perTxWr = 1'b1;
                    // a rewritten pointer is not stepped past
                    s_d.tx = stepDir(s_q.tx, s_q.ptrNew ? 3'h0 : incBytes);
                    s_d.state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (memAck) begin
                    s_d.rx = stepDir(s_q.rx, s_q.ptrNew ? 3'h0 : incBytes);
                    s_d.state = ST_IDLE;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
        if (wrNow) begin
            // a new pointer is used from the next item on
            if (wa == OFF_RX_PTR) begin
                s_d.rx.ptr = hwdata;
                if (s_d.state == ST_WRITE) begin
                    s_d.ptrNew = 1'b1;
                end
            end else if (wa == OFF_RX_CNT) begin
                s_d.rx.cnt = hwdata[15:0];
            end else if (wa == OFF_TX_PTR) begin
                s_d.tx.ptr = hwdata;
                if (s_d.state == ST_READ) begin
                    s_d.ptrNew = 1'b1;
                end
            end else if (wa == OFF_TX_CNT) begin
                s_d.tx.cnt = hwdata[15:0];
            end else if (wa == OFF_RX_NPTR) begin
                s_d.rx.nptr = hwdata;
            end else if (wa == OFF_RX_NCNT) begin
                s_d.rx.ncnt = hwdata[15:0];
            end else if (wa == OFF_TX_NPTR) begin
                s_d.tx.nptr = hwdata;
            end else if (wa == OFF_TX_NCNT) begin
                s_d.tx.ncnt = hwdata[15:0];
            end else if (wa == OFF_CTRL) begin
                // disable beats enable when both are written
                if (hwdata[BIT_RX_EN]) begin
                    s_d.rxEn = 1'b1;
                end
                if (hwdata[BIT_RX_DIS]) begin
                    s_d.rxEn = 1'b0;
                end
                if (hwdata[BIT_TX_EN]) begin
                    s_d.txEn = 1'b1;
                end
                if (hwdata[BIT_TX_DIS]) begin
                    s_d.txEn = 1'b0;
                end
                // half duplex: an rx enable turns tx off, else a tx enable turns rx off
                if (s_q.halfDuplex && hwdata[BIT_RX_EN]) begin
                    s_d.txEn = 1'b0;
                end else if (s_q.halfDuplex && hwdata[BIT_TX_EN]) begin
                    s_d.rxEn = 1'b0;
                end
            end else if (wa == OFF_MODE) begin
                s_d.halfDuplex = hwdata[BIT_HALF_DUPLEX];
                // the unused size code falls back to words
                if (hwdata[SZ_LSB+1:SZ_LSB] == 2'h3) begin
                    s_d.size = SZ_WORD;
                end else begin
                    s_d.size = pdmac_size_type'(hwdata[SZ_LSB+1:SZ_LSB]);
                end
            end
        end
        // a next set waiting behind an empty current one takes over
        if (s_d.rx.cnt == CNT_RESET && s_d.rx.ncnt != CNT_RESET) begin
            s_d.rx.ptr = s_d.rx.nptr;
            s_d.rx.cnt = s_d.rx.ncnt;
            s_d.rx.nptr = PTR_RESET;
            s_d.rx.ncnt = CNT_RESET;
        end
        if (s_d.tx.cnt == CNT_RESET && s_d.tx.ncnt != CNT_RESET) begin
            s_d.tx.ptr = s_d.tx.nptr;
            s_d.tx.cnt = s_d.tx.ncnt;
            s_d.tx.nptr = PTR_RESET;
            s_d.tx.ncnt = CNT_RESET;
        end
        // flags follow the counters; set wins since counters drive both
        s_d.rxEnd = s_d.rx.cnt == CNT_RESET;
        s_d.rxFull = s_d.rx.cnt == CNT_RESET && s_d.rx.ncnt == CNT_RESET;
        s_d.txEnd = s_d.tx.cnt == CNT_RESET;
        s_d.txEmpty = s_d.tx.cnt == CNT_RESET && s_d.tx.ncnt == CNT_RESET;
        // read data registered at the data-phase start
        s_d.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == OFF_RX_PTR) begin
                s_d.rdata = s_d.rx.ptr;
            end else if (haddr[7:0] == OFF_RX_CNT) begin
                s_d.rdata = {16'h0000, s_d.rx.cnt};
            end else if (haddr[7:0] == OFF_TX_PTR) begin
                s_d.rdata = s_d.tx.ptr;
            end else if (haddr[7:0] == OFF_TX_CNT) begin
                s_d.rdata = {16'h0000, s_d.tx.cnt};
            end else if (haddr[7:0] == OFF_RX_NPTR) begin
                s_d.rdata = s_d.rx.nptr;
            end else if (haddr[7:0] == OFF_RX_NCNT) begin
                s_d.rdata = {16'h0000, s_d.rx.ncnt};
            end else if (haddr[7:0] == OFF_TX_NPTR) begin
                s_d.rdata = s_d.tx.nptr;
            end else if (haddr[7:0] == OFF_TX_NCNT) begin
                s_d.rdata = {16'h0000, s_d.tx.ncnt};
            end else if (haddr[7:0] == OFF_STAT) begin
                s_d.rdata[BIT_RX_EN] = s_d.rxEn;
                s_d.rdata[BIT_TX_EN] = s_d.txEn;
            end else if (haddr[7:0] == OFF_FLAGS) begin
                s_d.rdata[BIT_RX_END] = s_d.rxEnd;
                s_d.rdata[BIT_TX_END] = s_d.txEnd;
                s_d.rdata[BIT_RX_FULL] = s_d.rxFull;
                s_d.rdata[BIT_TX_EMPTY] = s_d.txEmpty;
            end else if (haddr[7:0] == OFF_MODE) begin
                s_d.rdata[BIT_HALF_DUPLEX] = s_d.halfDuplex;
                s_d.rdata[SZ_LSB+1:SZ_LSB] = s_d.size;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.rxEnd <= 1'b1;
            s_q.txEnd <= 1'b1;
            s_q.rxFull <= 1'b1;
            s_q.txEmpty <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers with no wait states, always okay
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign perTxData = s_q.data;
    assign perTxWrite = s_q.perTxWr;
    assign perRxRead = s_q.perRxRd;
    assign rxEndFlag = s_q.rxEnd;
    assign txEndFlag = s_q.txEnd;
    assign rxBufferFullFlag = s_q.rxFull;
    assign txBufferEmptyFlag = s_q.txEmpty;
    assign rxEnabled = s_q.rxEn;
    assign txEnabled = s_q.txEn;
    assign memReq = s_q.state != ST_IDLE;
    assign memWrite = s_q.state == ST_WRITE;
    assign memAddr = s_q.addr;
    assign memWdata = s_q.data;
    assign memSize = s_q.size;
endmodule

//--- hw/pdmac_pkg.sv
// package for the peripheral dma channel: register map, fields, types
package pdmac_pkg;
    localparam logic [7:0] OFF_RX_PTR = 8'h00;
    localparam logic [7:0] OFF_RX_CNT = 8'h04;
    localparam logic [7:0] OFF_TX_PTR = 8'h08;
    localparam logic [7:0] OFF_TX_CNT = 8'h0C;
    localparam logic [7:0] OFF_RX_NPTR = 8'h10;
    localparam logic [7:0] OFF_RX_NCNT = 8'h14;
    localparam logic [7:0] OFF_TX_NPTR = 8'h18;
    localparam logic [7:0] OFF_TX_NCNT = 8'h1C;
    localparam logic [7:0] OFF_CTRL = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h24;
    localparam logic [7:0] OFF_FLAGS = 8'h28;
    localparam logic [7:0] OFF_MODE = 8'h2C;
    // transfer control bits
    localparam int BIT_RX_EN = 0;
    localparam int BIT_RX_DIS = 1;
    localparam int BIT_TX_EN = 8;
    localparam int BIT_TX_DIS = 9;
    // status bits (enable state at the same positions as enable bits)
    localparam int BIT_RX_END = 0;
    localparam int BIT_TX_END = 1;
    localparam int BIT_RX_FULL = 2;
    localparam int BIT_TX_EMPTY = 3;
    localparam int BIT_HALF_DUPLEX = 0;
    localparam int SZ_LSB = 1;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } pdmac_size_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } pdmac_state_type;

    typedef struct packed {
        logic [31:0] ptr;
        logic [15:0] cnt;
        logic [31:0] nptr;
        logic [15:0] ncnt;
    } pdmac_dir_type;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } pdmac_bus_type;
endpackage

//--- tb/pdmac_chk.sv
// port checker for the peripheral dma channel
`timescale 1ns/10ps
module pdmac_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // state and flags
    input wire logic rxEnabled,
    input wire logic txEnabled,
    input wire logic rxEndFlag,
    input wire logic txEndFlag,
    input wire logic rxBufferFullFlag,
    input wire logic txBufferEmptyFlag,
    // peripheral side
    input wire logic perRxRead,
    input wire logic perTxWrite,
    input wire logic [31:0] perTxData,
    // memory side
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [1:0] memSize,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    reset_clear_a: assert property ($rose(rst_b) |-> !rxEnabled && !txEnabled
        && rxBufferFullFlag && txBufferEmptyFlag) else $error("reset state");
    rx_flags_a: assert property (rxBufferFullFlag |-> rxEndFlag)
        else $error("rx full without rx end");
    tx_flags_a: assert property (txBufferEmptyFlag |-> txEndFlag)
        else $error("tx empty without tx end");
    mem_hold_a: assert property (memReq && !memAck |=> memReq
        && $stable(memAddr) && $stable(memWrite)) else $error("request moved");
    ack_drop_a: assert property (memReq && memAck |=> !memReq)
        else $error("request after ack");
    tx_data_a: assert property (memReq && memAck && !memWrite |=>
        perTxWrite && perTxData == $past(memRdata)) else $error("tx data");
    rx_write_a: assert property (perRxRead |-> memReq && memWrite)
        else $error("rx item not written");
    size_ok_a: assert property (memReq |-> memSize != 2'b11)
        else $error("bad item size");
endmodule
bind pdmac_channel pdmac_chk pdmac_chk_inst (.ref_clk, .rst_b, .rxEnabled,
    .txEnabled, .rxEndFlag, .txEndFlag, .rxBufferFullFlag, .txBufferEmptyFlag,
    .perRxRead, .perTxWrite, .perTxData, .memReq, .memWrite, .memAddr,
    .memSize, .memAck, .memRdata);

//--- tb/pdmac_far.sv
// serial peripheral and memory model facing the channel
`timescale 1ns/10ps
module pdmac_far (
    // clock, reset, memory pacing and peripheral item supply
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] slow,
    input wire logic [3:0] rxMore,
    input wire logic [3:0] txMore,
    // peripheral side
    output logic rxReady,
    output logic txReady,
    output logic [31:0] perRxData,
    input wire logic perRxRead,
    input wire logic perTxWrite,
    input wire logic [31:0] perTxData,
    // memory side
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic [31:0] memRdata
);
    logic [31:0] mem [0:63];
    logic [31:0] addrLog [0:15];
    logic [31:0] txLast;
    int logN = 0, rxPend = 0, txPend = 0, w;
    initial for (int i = 0; i < 64; i++) mem[i] = 32'hA500_0000 + 32'(i);
    assign perRxData = 32'hC0DE_0000 | 32'(rxPend);
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            memAck <= 1'b0;
            rxReady <= 1'b0;
            txReady <= 1'b0;
            memRdata <= 32'h5A5A_0F0F;
            w <= 0;
        end else begin
            // drop ready once taken, or the stale sync would move another
            rxReady <= rxPend - perRxRead > 0 && !(memReq && memWrite);
            txReady <= txPend - perTxWrite > 0 && !(memReq && !memWrite);
            rxPend <= rxPend + int'(rxMore) - int'(perRxRead);
            txPend <= txPend + int'(txMore) - int'(perTxWrite);
            if (perTxWrite) txLast <= perTxData;
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq && !memAck) begin
                w <= w + 1;
                if (w == slow + 1) begin
                    w <= 0;
                    memAck <= 1'b1;
                    memRdata <= mem[memAddr[7:2]];
                    addrLog[logN[3:0]] <= memAddr;
                    logN <= logN + 1;
                    if (memWrite) mem[memAddr[7:2]] <= memWdata;
                end
            end
        end
    end
endmodule

//--- tb/tb_peripheral_dma_channel.sv
// self-checking bench for the peripheral dma channel
`timescale 1ns/10ps
module tb_peripheral_dma_channel;
    import pdmac_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'b00, memSize;
    logic [2:0] hsize = 3'b010;
    logic [3:0] slow = 4'h0;
    logic [3:0] rxMore = 4'h0, txMore = 4'h0, flagPins;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, perRxData, perTxData;
    logic [31:0] memAddr, memWdata, memRdata, rd;
    logic hreadyout, hresp, rxReady, txReady, perTxWrite, perRxRead, memReq;
    logic memWrite, memAck, rxEndFlag, txEndFlag, rxBufferFullFlag;
    logic txBufferEmptyFlag, rxEnabled, txEnabled;
    int nMismatch = 0, cmpCount = 0;
    always #10 ref_clk = ~ref_clk;
    assign flagPins = {rxEndFlag, txEndFlag, rxBufferFullFlag,
        txBufferEmptyFlag};
    pdmac_channel pdmac_channel_inst (.ref_clk, .rst_b, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .rxReady, .txReady, .perRxData, .perTxData,
        .perTxWrite, .perRxRead, .rxEndFlag, .txEndFlag, .rxBufferFullFlag,
        .txBufferEmptyFlag, .rxEnabled, .txEnabled, .memReq, .memWrite,
        .memAddr, .memWdata, .memSize, .memAck, .memRdata);
    pdmac_far pdmac_far_inst (.ref_clk, .rst_b, .slow, .rxMore, .txMore,
        .rxReady, .txReady, .perRxData, .perRxRead, .perTxWrite, .perTxData,
        .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata);
    task conclude;
        if (nMismatch == 0 && cmpCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        cmpCount++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task chkRd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask
    task waitLog(input int n);
        for (int i = 0; i < 500 && pdmac_far_inst.logN < n; i++)
            @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
    endtask
    // peripheral gets items to move; pulsed for one cycle
    task give(input logic [3:0] r, input logic [3:0] t);
        rxMore <= r;
        txMore <= t;
        @(posedge ref_clk);
        rxMore <= 4'h0;
        txMore <= 4'h0;
    endtask
    task resetValues;
        for (int i = 0; i < 8; i++) chkRd(8'(4 * i), 32'h0);
        chkRd(OFF_STAT, 32'h0);
        chkRd(OFF_FLAGS, 32'hF);
        wr(8'h30, 32'hFFFF_FFFF);
        chkRd(8'h30, 32'h0);
    endtask
    task rxReload;
        wr(OFF_MODE, 32'h4);
        wr(OFF_RX_PTR, 32'h40);
        wr(OFF_RX_CNT, 32'h2);
        wr(OFF_RX_NPTR, 32'h80);
        wr(OFF_RX_NCNT, 32'h1);
        chkRd(OFF_FLAGS, 32'hA);
        give(4'h3, 4'h0);
        wr(OFF_CTRL, 32'h1);
        chkRd(OFF_STAT, 32'h1);
        waitLog(3);
        cmp(pdmac_far_inst.addrLog[0], 32'h40);
        cmp(pdmac_far_inst.addrLog[2], 32'h80);
        cmp(pdmac_far_inst.mem[16], 32'hC0DE_0003);
        chkRd(OFF_RX_PTR, 32'h84);
        chkRd(OFF_RX_NPTR, 32'h0);
        chkRd(OFF_RX_CNT, 32'h0);
        chkRd(OFF_FLAGS, 32'hF);
        // the peripheral raises its end interrupt from these pins
        cmp(32'(flagPins), 32'hF);
    endtask
    task txSizes;
        for (int s = 0; s < 3; s++) begin
            slow <= 4'(s);
            wr(OFF_MODE, 32'(s << 1));
            wr(OFF_TX_PTR, 32'h20);
            wr(OFF_TX_CNT, 32'h2);
            give(4'h0, 4'h2);
            wr(OFF_CTRL, 32'h100);
            waitLog(5 + 2 * s);
            cmp(pdmac_far_inst.addrLog[4 + 2 * s], 32'h20 + (1 << s));
            chkRd(OFF_TX_PTR, 32'h20 + (2 << s));
            cmp(pdmac_far_inst.txLast, 32'hA500_0008 + 32'(s >> 1));
            chkRd(OFF_FLAGS, 32'hF);
        end
    endtask
    task disabledRefused;
        wr(OFF_CTRL, 32'h303);
        chkRd(OFF_STAT, 32'h0);
        wr(OFF_RX_CNT, 32'h5);
        give(4'h1, 4'h0);
        repeat (20) @(posedge ref_clk);
        cmp(32'(pdmac_far_inst.logN), 32'h9);
        chkRd(OFF_RX_CNT, 32'h5);
        chkRd(OFF_FLAGS, 32'hA);
        cmp(32'(flagPins), 32'h5);
    endtask
    task ptrRewrite;
        wr(OFF_RX_PTR, 32'h40);
        wr(OFF_RX_CNT, 32'h2);
        wr(OFF_CTRL, 32'h1);
        waitLog(10);
        wr(OFF_RX_PTR, 32'hA0);
        give(4'h1, 4'h0);
        waitLog(11);
        cmp(pdmac_far_inst.addrLog[10], 32'hA0);
        chkRd(OFF_RX_PTR, 32'hA4);
    endtask
    task halfDuplex;
        wr(OFF_MODE, 32'h5);
        wr(OFF_CTRL, 32'h100);
        chkRd(OFF_STAT, 32'h100);
        cmp(32'({rxEnabled, txEnabled}), 32'h1);
        wr(OFF_CTRL, 32'h1);
        chkRd(OFF_STAT, 32'h1);
        cmp(32'({rxEnabled, txEnabled}), 32'h2);
    endtask
    initial begin
        repeat (8000) @(posedge ref_clk);
        nMismatch++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        resetValues();
        rxReload();
        txSizes();
        disabledRefused();
        ptrRewrite();
        halfDuplex();
        conclude();
    end
endmodule
